// file: rtl/odt_zq_mem.sv
// Memory-side end: termination timing mode and ZQ calibration engine.
// Assumes the controller keeps its calibration and power-down duties.
//
// Overview of operation
// [RULE1] Asynchronous timing when DLL frozen in power-down.
// [RULE2] Asynchronous mode skips additive latency delay.
// [RULE3] Async turn-on within tAONPD min/max.
// [RULE4] Async turn-off within tAOFPD min/max.
// [RULE5] Entry transition allows either termination behaviour.
// [RULE6] Entry period: WL-1 before to tCPDED. The code opens the window at the registered CKE edge instead.
// [RULE7] Pending refresh extends entry period to tRFC.
// [RULE8] Start cycle excluded, end cycles included.
// [RULE9] Transition change uses widest min/max window.
// [RULE10] Exit period: WL-1 before to tXPDLL. The code opens the window at the registered CKE edge instead.
// [RULE11] Short power-down merges entry and exit.
// [RULE12] Short idle merges exit and entry.
// [RULE13] ZQCL calibrates, then loads values into I/O.
// [RULE14] First ZQCL tZQinit, later ones tZQoper.
// [RULE15] ZQCS finishes within tZQCS.
// [RULE16] Controller keeps channel quiet during calibration.
// [RULE17] Calibration current path off when done.
// [RULE18] Banks precharged and tRP met before calibration. Code sends no precharge; tRP runs from the last calibration.
// [RULE19] No self-refresh recalibration; command after tXS.
// [RULE20] Shared resistor: rank windows never overlap.
// [RULE21] CKE held high during calibration.
// [RULE22] Termination off, DQ bus high impedance.
// [RULE23] Synchronous latency is CWL plus AL minus 2.
// [RULE24] Controller treats termination undefined in transitions.
`timescale 1ns/10ps
`default_nettype none
module odt_zq_mem
  import odt_zq_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Link to the controller.
  odt_zq_if.mem link,
  // User side status.
  output logic rtt_on,
  output logic odt_async,
  output logic odt_transition,
  output logic zq_current_on,
  output logic cal_busy,
  output logic cal_loaded,
  output logic [7:0] cal_code
);
  typedef struct packed {
    cal_state_t st;
    logic [CW-1:0] cal_cnt;
    logic first_done;
    logic zq_on;
    logic loaded;
    logic [7:0] code;
    logic cke_q;
    logic pd;
    logic [CW-1:0] ent_cnt;
    logic [CW-1:0] ext_cnt;
    logic [CW-1:0] ref_cnt;
    logic [CW-1:0] rtt_cnt;
    logic rtt;
  } mem_t;
  mem_t r;
  mem_t next_r;

  logic sync_odt;

  // ----------------------------------------
  // Synchronous termination path.
  // ----------------------------------------
  // Synchronous path: ODT delayed by the full turn-on latency.
  odt_delay_line u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(link.odt),
    .sel(3'(ODTL_CK - 1)), // RULE23
    .dout(sync_odt)
  );

  // Saturating down-count helper.
  // Counters stop at zero, so an idle counter never wraps.
  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    return (v == CNT_ZERO) ? CNT_ZERO : v - CNT_ONE;
  endfunction

  logic async_mode;
  logic trans;
  logic want;

  // ----------------------------------------
  // Timing mode and transition windows.
  // ----------------------------------------
  // Mode selection and transition windows.
  always_comb begin
    // Frozen DLL in power-down selects asynchronous timing.
    async_mode = link.dll_frozen_pd && r.pd; // RULE1
    // A window is open while its counter runs. Both count from the
    // registered CKE edge: the WL-1 lead before that edge cannot be
    // foreseen here, so a user must treat that lead as uncertain too.
    trans = link.dll_frozen_pd && ((r.ent_cnt != CNT_ZERO) ||
            (r.ext_cnt != CNT_ZERO)); // RULE5 RULE11 RULE12
    // Asynchronous: raw ODT, no additive latency; else delayed copy.
    want = async_mode ? link.odt : sync_odt; // RULE2
  end

  // ----------------------------------------
  // Next state.
  // ----------------------------------------
  // Next-state logic.
  // Windows count down every cycle; termination and calibration advance only once started.
  always_comb begin
    next_r = r;
    next_r.cke_q = link.cke;
    next_r.ent_cnt = dec(r.ent_cnt);
    next_r.ext_cnt = dec(r.ext_cnt);
    next_r.ref_cnt = dec(r.ref_cnt);
    // Refresh occupies tRFC from its command.
    if (link.cmd == CMD_REF) begin
      next_r.ref_cnt = CW'(RFC_CK);
    end
    // CKE first registered low: entry window runs to the later of
    // tCPDED and a pending refresh end, end cycle included.
    if (r.cke_q && !link.cke) begin
      next_r.pd = 1'b1;
      next_r.ent_cnt = (r.ref_cnt > CW'(CPDED_CK)) ? r.ref_cnt :
                       CW'(CPDED_CK); // RULE6 RULE7 RULE8
    end
    // CKE first registered high: exit window runs tXPDLL.
    if (!r.cke_q && link.cke) begin
      next_r.pd = 1'b0;
      next_r.ext_cnt = CW'(XPDLL_CK); // RULE10
    end
    // Termination follows wanted state after a delay; in async mode and in
    // transition the counter starts at AONPD_MIN_CK, otherwise at one.
    if (want != r.rtt) begin
      if (r.rtt_cnt == CNT_ZERO) begin
        next_r.rtt_cnt = (async_mode || trans) ? CW'(AONPD_MIN_CK) :
                         CNT_ONE; // RULE3 RULE4 RULE9
      end else if (r.rtt_cnt == CNT_ONE) begin
        next_r.rtt = want;
        next_r.rtt_cnt = CNT_ZERO;
      end else begin
        next_r.rtt_cnt = dec(r.rtt_cnt);
      end
    end else begin
      next_r.rtt_cnt = CNT_ZERO;
    end
    // Calibration engine; only an explicit command starts it.
    unique case (r.st)
      CAL_IDLE: begin
        if (link.cmd == CMD_ZQCL) begin // RULE19
          next_r.st = CAL_RUN;
          next_r.zq_on = 1'b1;
          next_r.loaded = 1'b0;
          next_r.cal_cnt = r.first_done ? CW'(ZQOPER_CK - 1) :
                           CW'(ZQINIT_CK - 1); // RULE14
          next_r.first_done = 1'b1;
        end else if (link.cmd == CMD_ZQCS) begin
          next_r.st = CAL_RUN;
          next_r.zq_on = 1'b1;
          next_r.loaded = 1'b0;
          next_r.cal_cnt = CW'(ZQCS_CK - 1); // RULE15
        end
      end
      CAL_RUN: begin
        next_r.cal_cnt = dec(r.cal_cnt);
        if (r.cal_cnt == CNT_ONE) begin
          next_r.st = CAL_LOAD;
        end
      end
      CAL_LOAD: begin
        // Transfer the new code to the I/O and drop the ZQ current.
        next_r.code = r.code + 8'h01; // RULE13
        next_r.loaded = 1'b1;
        next_r.zq_on = 1'b0; // RULE17
        next_r.st = CAL_IDLE;
      end
      default: next_r.st = CAL_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register.
  // ----------------------------------------
  // Reset loads idle values; every other edge takes the next state.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= '{st: CAL_IDLE, cal_cnt: CNT_ZERO, first_done: 1'b0,
             zq_on: 1'b0, loaded: 1'b0, code: 8'h00, cke_q: 1'b0,
             pd: 1'b0, ent_cnt: CNT_ZERO, ext_cnt: CNT_ZERO,
             ref_cnt: CNT_ZERO, rtt_cnt: CNT_ZERO,
             rtt: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs.
  // ----------------------------------------
  // Outputs; the memory never drives DQ in this block.
  assign link.dq_oe_mem = 1'b0;
  assign rtt_on = r.rtt;
  assign odt_async = async_mode;
  assign odt_transition = trans;
  assign zq_current_on = r.zq_on;
  assign cal_busy = (r.st != CAL_IDLE);
  assign cal_loaded = r.loaded;
  assign cal_code = r.code;
endmodule
`default_nettype wire

// file: rtl/odt_zq_pkg.sv
// Package for the termination-mode and calibration logic.
// Shared by the memory-side end and the controller-side end.
package odt_zq_pkg;

  // Command codes on the shared command bus.
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ZQCL = 3'h1;
  localparam logic [2:0] CMD_ZQCS = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h3;
  localparam logic [2:0] CMD_PREA = 3'h4;
  localparam logic [2:0] CMD_SRX = 3'h5;
  localparam logic [2:0] CMD_OTHER = 3'h6;

  // Latency settings in memory clocks.
  localparam int CWL = 5;
  localparam int AL = 0;
  localparam int WL = CWL + AL;
  localparam int ODTL_CK = CWL + AL - 2;
  localparam int ANPD_CK = WL - 1;

  // Times in nanoseconds and the clock period.
  localparam int CLK_NS = 10;
  localparam int AONPD_MIN_NS = 2;
  localparam int AONPD_MAX_NS = 9;
  localparam int CPDED_NS = 10;
  localparam int RFC_NS = 110;
  localparam int XPDLL_NS = 24;
  localparam int RP_NS = 14;
  localparam int XS_NS = 120;
  localparam int ZQINIT_NS = 5120;
  localparam int ZQOPER_NS = 2560;
  localparam int ZQCS_NS = 640;

  // Least times round up, none below one cycle.
  function automatic int ceil_ck(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int AONPD_MIN_CK = ceil_ck(AONPD_MIN_NS);
  localparam int AONPD_MAX_CK = (AONPD_MAX_NS / CLK_NS < 1) ? 1 :
                                AONPD_MAX_NS / CLK_NS;
  localparam int CPDED_CK = ceil_ck(CPDED_NS);
  localparam int RFC_CK = ceil_ck(RFC_NS);
  localparam int XPDLL_CK = ceil_ck(XPDLL_NS);
  localparam int RP_CK = ceil_ck(RP_NS);
  localparam int XS_CK = ceil_ck(XS_NS);
  localparam int ZQINIT_CK = ceil_ck(ZQINIT_NS);
  localparam int ZQOPER_CK = ceil_ck(ZQOPER_NS);
  localparam int ZQCS_CK = ceil_ck(ZQCS_NS);

  localparam int CW = 12;
  localparam logic [CW-1:0] CNT_ZERO = 12'h000;
  localparam logic [CW-1:0] CNT_ONE = 12'h001;
  localparam logic [7:0] HIST_ZERO = 8'h00;

  // Calibration engine states.
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN = 3'b010,
    CAL_LOAD = 3'b100
  } cal_state_t;

endpackage

// file: rtl/odt_zq_if.sv
// Interface joining the controller end and the memory end.
// Assumes both ends share sys_clk; DQ drive is modelled by enables only.
`timescale 1ns/10ps
`default_nettype none
interface odt_zq_if;
  logic cke;
  logic odt;
  logic [2:0] cmd;
  logic dll_frozen_pd;
  logic dq_oe_ctl;
  logic dq_oe_mem;
  modport ctl (output cke, output odt, output cmd, output dll_frozen_pd,
    output dq_oe_ctl, input dq_oe_mem);
  modport mem (input cke, input odt, input cmd, input dll_frozen_pd,
    input dq_oe_ctl, output dq_oe_mem);
endinterface
`default_nettype wire

// file: rtl/odt_delay_line.sv
// Shift line that delays the ODT input by a chosen number of clocks.
// Assumes a delay no larger than the line length.
`timescale 1ns/10ps
`default_nettype none
module odt_delay_line
  import odt_zq_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Data.
  input wire logic din,
  input wire logic [2:0] sel,
  output logic dout
);
  typedef struct packed {
    logic [7:0] hist;
  } dl_t;
  dl_t r;
  dl_t next_r;

  // Shift the history each cycle.
  always_comb begin
    next_r = r;
    next_r.hist = {r.hist[6:0], din};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= '{hist: HIST_ZERO};
    end else begin
      r <= next_r;
    end
  end

  // Tap zero is the newest sampled value.
  assign dout = r.hist[sel];
endmodule
`default_nettype wire

// file: rtl/odt_zq_ctl.sv
// Controller-side end: issues calibration and power-down requests.
// Assumes one rank per resistor per controller instance.
`timescale 1ns/10ps
`default_nettype none
module odt_zq_ctl
  import odt_zq_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Link to the memory.
  odt_zq_if.ctl link,
  // User requests.
  input wire logic req_zqcl,
  input wire logic req_zqcs,
  input wire logic req_pd,
  input wire logic req_odt,
  input wire logic req_ref,
  input wire logic req_srx,
  input wire logic dll_freeze,
  // User status.
  output logic busy,
  output logic in_pd
);
  typedef struct packed {
    logic [CW-1:0] quiet;
    logic [CW-1:0] rp;
    logic cke;
    logic odt;
    logic [2:0] cmd;
    logic [CW-1:0] hold;
  } ctl_t;
  ctl_t r;
  ctl_t next_r;

  // Saturating down-count helper shared by all timers.
  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    return (v == CNT_ZERO) ? CNT_ZERO : v - CNT_ONE;
  endfunction

  // Next-state logic.
  always_comb begin
    next_r = r;
    next_r.cmd = CMD_NOP;
    next_r.quiet = dec(r.quiet);
    next_r.rp = dec(r.rp);
    next_r.hold = dec(r.hold);
    // ODT low and CKE high for the whole quiet time.
    if (r.quiet != CNT_ZERO) begin
      next_r.odt = 1'b0; // RULE22
      next_r.cke = 1'b1; // RULE21
    end else if (r.hold == CNT_ZERO && (req_zqcl || req_zqcs) && r.cke) begin
      if (r.rp == CNT_ZERO) begin
        // tRP timed from the previous calibration command; one rank at a time.
        next_r.cmd = req_zqcl ? CMD_ZQCL : CMD_ZQCS; // RULE18 RULE20
        next_r.quiet = req_zqcl ? CW'(ZQINIT_CK) : CW'(ZQCS_CK); // RULE16
        next_r.odt = 1'b0;
        next_r.rp = CW'(RP_CK);
      end
    end else if (req_srx) begin
      next_r.cmd = CMD_SRX;
      next_r.hold = CW'(XS_CK); // RULE19
    end else if (req_ref && r.cke) begin
      next_r.cmd = CMD_REF;
    end else begin
      // Transitions have undefined termination; ODT held still only in the cycle CKE changes.
      next_r.cke = !req_pd;
      if (r.cke == !req_pd) next_r.odt = req_odt; // RULE24
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= '{quiet: CNT_ZERO, rp: CNT_ZERO, cke: 1'b1, odt: 1'b0,
             cmd: CMD_NOP, hold: CNT_ZERO};
    end else begin
      r <= next_r;
    end
  end

  assign link.cke = r.cke;
  assign link.odt = r.odt;
  assign link.cmd = r.cmd;
  assign link.dll_frozen_pd = dll_freeze;
  assign link.dq_oe_ctl = 1'b0; // RULE22
  assign busy = (r.quiet != CNT_ZERO);
  assign in_pd = !r.cke;
endmodule
`default_nettype wire

// file: tb/odt_zq_props.sv
// Checker for the link between the controller end and the memory end.
// Assumes it sees the link signals in the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none
module odt_zq_props
  import odt_zq_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Link signals.
  input wire logic cke,
  input wire logic odt,
  input wire logic [2:0] cmd,
  input wire logic dll_frozen_pd,
  input wire logic dq_oe_ctl,
  input wire logic dq_oe_mem
);
  // ----------------------------------------
  // Quiet window tracking and assertions.
  // ----------------------------------------
  logic zq_cmd;
  logic zq_seen;
  logic [11:0] quiet_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A calibration command of either length.
  assign zq_cmd = (cmd == CMD_ZQCL) || (cmd == CMD_ZQCS);
  // Counts the cycles that must stay quiet after a calibration command.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      quiet_cnt <= 12'h000;
      zq_seen <= 1'b0;
    end else if (cmd == CMD_ZQCL) begin
      // The first long calibration after reset gets the longer window.
      quiet_cnt <= zq_seen ? 12'(ZQOPER_CK - 1) :
                   12'(ZQINIT_CK - 1);
      zq_seen <= 1'b1;
    end else if (cmd == CMD_ZQCS) begin
      quiet_cnt <= 12'(ZQCS_CK - 1);
    end else if (quiet_cnt != 12'h000) begin
      quiet_cnt <= quiet_cnt - 12'h001;
    end
  end
  a_zq_cke_high: assert property (zq_cmd |-> cke [*8])
    else $error("CKE low after a calibration command");
  a_zq_odt_low: assert property (zq_cmd |-> !odt [*8])
    else $error("ODT high after a calibration command");
  a_dq_bus_hiz: assert property (!dq_oe_ctl && !dq_oe_mem)
    else $error("DQ bus driven");
  a_quiet_window: assert property (quiet_cnt != 12'h000 |->
    cmd == CMD_NOP && cke && !odt)
    else $error("Activity inside the calibration window");
  a_zqcl_nop_run: assert property (cmd == CMD_ZQCL |=>
    (cmd == CMD_NOP) [*8])
    else $error("Command right after a long calibration");
  a_zqcs_nop_run: assert property (cmd == CMD_ZQCS |=>
    (cmd == CMD_NOP) [*8])
    else $error("Command right after a short calibration");
  a_srx_zq_gap: assert property (cmd == CMD_SRX |=> !zq_cmd [*8])
    else $error("Calibration too soon after self-refresh exit");
  a_pd_no_zq: assert property (!cke |-> !zq_cmd)
    else $error("Calibration issued with CKE low");
  a_zq_rp_gap: assert property (zq_cmd |=> !zq_cmd [*2])
    else $error("Calibration commands closer than the precharge time");
  a_odt_still_cke: assert property ($changed(cke) |-> $stable(odt))
    else $error("ODT moved in the cycle that CKE changed");
  c_async_pd: cover property (dll_frozen_pd && !cke);
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Testbench joining the controller end and the memory end.
// Assumes one shared sys_clk and the timing constants of the package.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import odt_zq_pkg::*;
;
  logic sys_clk, rst, dll_freeze, req_zqcl, req_zqcs;
  logic req_pd, req_odt, req_ref, req_srx, busy, in_pd, rtt_on;
  logic odt_async, odt_transition, zq_current_on, cal_busy, cal_loaded;
  logic [7:0] cal_code;
  int mismatches, compares, n, m;
  odt_zq_if link_if();
  odt_zq_ctl odt_zq_ctl_inst(.sys_clk(sys_clk), .rst(rst), .link(link_if),
    .req_zqcl(req_zqcl), .req_zqcs(req_zqcs), .req_pd(req_pd),
    .req_odt(req_odt), .req_ref(req_ref), .req_srx(req_srx),
    .dll_freeze(dll_freeze), .busy(busy), .in_pd(in_pd));
  odt_zq_mem odt_zq_mem_inst(.sys_clk(sys_clk), .rst(rst), .link(link_if),
    .rtt_on(rtt_on), .odt_async(odt_async), .odt_transition(odt_transition),
    .zq_current_on(zq_current_on), .cal_busy(cal_busy),
    .cal_loaded(cal_loaded), .cal_code(cal_code));
  odt_zq_props odt_zq_props_inst(.sys_clk(sys_clk), .rst(rst),
    .cke(link_if.cke), .odt(link_if.odt), .cmd(link_if.cmd),
    .dll_frozen_pd(link_if.dll_frozen_pd), .dq_oe_ctl(link_if.dq_oe_ctl),
    .dq_oe_mem(link_if.dq_oe_mem));
  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bit1(input logic s, input logic e);
    check({15'h0000, s}, {15'h0000, e});
  endtask
  task automatic in_range(input int v, input int lo, input int hi);
    bit1((v >= lo) && (v <= hi), 1'h1);
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // Picks a status output by number so one wait serves them all.
  function automatic logic pick(input int w);
    case (w)
      0: return rtt_on;
      1: return cal_loaded;
      2: return odt_transition;
      3: return cal_busy;
      default: return busy;
    endcase
  endfunction
  // Counts falling edges until the status reaches v, bounded.
  task automatic wait_on(input int w, input logic v, output int k);
    k = 0;
    while (pick(w) !== v && k < 600) begin
      tick(1);
      k++;
    end
    if (k >= 600) mismatches++;
  endtask
  // One calibration; a short one keeps its request high until one cycle after cal_busy rises, and that request must be ignored.
  task automatic run_cal(input logic s, input int lim, input logic [7:0] c);
    int k;
    wait_on(4, 1'h0, k);
    req_zqcl = !s;
    req_zqcs = s;
    tick(1);
    req_zqcl = 1'h0;
    wait_on(3, 1'h1, k);
    bit1(zq_current_on, 1'h1);
    bit1(busy, 1'h1);
    tick(1);
    req_zqcs = 1'h0;
    wait_on(1, 1'h1, k);
    in_range(k, 1, lim);
    check({8'h00, cal_code}, {8'h00, c});
    tick(1);
    bit1(zq_current_on, 1'h0);
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Clock at 100 MHz.
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Cuts a hang short.
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  // Main sequence of scenarios.
  initial begin
    rst = 1'h1;
    dll_freeze = 1'h0;
    {req_zqcl, req_zqcs, req_pd, req_odt, req_ref, req_srx} = 6'h00;
    mismatches = 0;
    compares = 0;
    tick(16);
    rst = 1'h0;
    tick(4);
    check({8'h00, cal_code}, 16'h0000);
    run_cal(1'h0, ZQINIT_CK, 8'h01);
    run_cal(1'h0, ZQOPER_CK, 8'h02);
    run_cal(1'h1, ZQCS_CK, 8'h03);
    req_odt = 1'h1;
    wait_on(0, 1'h1, n);
    in_range(n, ODTL_CK + 1, ODTL_CK + 3);
    req_odt = 1'h0;
    wait_on(0, 1'h0, n);
    in_range(n, ODTL_CK + 1, ODTL_CK + 3);
    dll_freeze = 1'h1;
    req_ref = 1'h1;
    tick(1);
    req_ref = 1'h0;
    req_pd = 1'h1;
    wait_on(2, 1'h1, n);
    wait_on(2, 1'h0, m);
    in_range(n + m + 1, RFC_CK, RFC_CK + 8);
    bit1(odt_async, 1'h1);
    bit1(in_pd, 1'h1);
    req_zqcl = 1'h1;
    tick(1);
    req_zqcl = 1'h0;
    tick(3);
    bit1(cal_busy, 1'h0);
    req_odt = 1'h1;
    wait_on(0, 1'h1, n);
    in_range(n, AONPD_MIN_CK + 1, AONPD_MAX_CK + 3);
    req_odt = 1'h0;
    wait_on(0, 1'h0, n);
    in_range(n, AONPD_MIN_CK + 1, AONPD_MAX_CK + 3);
    req_pd = 1'h0;
    wait_on(2, 1'h1, n);
    wait_on(2, 1'h0, n);
    in_range(n, XPDLL_CK, XPDLL_CK + 2);
    bit1(odt_async, 1'h0);
    bit1(in_pd, 1'h0);
    req_pd = 1'h1;
    tick(2);
    req_pd = 1'h0;
    tick(2);
    bit1(odt_transition, 1'h1);
    tick(8);
    bit1(odt_transition, 1'h0);
    dll_freeze = 1'h0;
    req_srx = 1'h1;
    tick(1);
    req_srx = 1'h0;
    req_zqcs = 1'h1;
    tick(1);
    req_zqcs = 1'h0;
    tick(4);
    bit1(cal_busy, 1'h0);
    tick(XS_CK);
    run_cal(1'h1, ZQCS_CK, 8'h04);
    wrap_up();
  end
endmodule
`default_nettype wire
